/* File: rtl/ebt_timer.sv */
// Eight-bit up-counting timer with preload, prescaler, interrupt and wake-up
`timescale 1ns/100ps
module ebt_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic subOscClk,
  input wire logic powerDown,
  input wire logic [ebt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ebt_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [ebt_pkg::DATA_W-1:0] regRdData,
  output logic irq,
  output logic wakeup
);
  // Register state
  ebt_pkg::ebt_ctrl_t ctrl_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic [7:0] preload_reg;
  logic [ebt_pkg::NUM_EVENTS-1:0] intStatus_reg;
  logic [ebt_pkg::NUM_EVENTS-1:0] intMask_reg;
  logic [7:0] rdData_reg;
  logic [7:0] rdData_next;
  logic wakeup_reg;

  // Address decode
  wire selCtrl = regAddr == ebt_pkg::OFF_CTRL;
  wire selCount = regAddr == ebt_pkg::OFF_COUNT;
  wire selStatus = regAddr == ebt_pkg::OFF_INT_STATUS;
  wire selMask = regAddr == ebt_pkg::OFF_INT_MASK;
  wire selSet = regAddr == ebt_pkg::OFF_INT_SET;

  wire wrCtrl = regWrEn & selCtrl;
  wire wrCount = regWrEn & selCount;
  wire wrStatus = regWrEn & selStatus;
  wire wrMask = regWrEn & selMask;
  wire wrSet = regWrEn & selSet;
  wire rdCount = regRdEn & selCount;

  // Counting clock is held off for the access cycle; a lost count is accepted
  wire countInhibit = rdCount | wrCount;

  // Sub-oscillator arrives as a pin, so it is synchronised before use
  logic subTick;
  logic timerTick;

  ebt_edge_sync subSync (
    .sys_clk(sys_clk),
    .rst(rst),
    .asyncIn(subOscClk),
    .risePulse(subTick)
  );

  ebt_prescaler prescaler (
    .sys_clk(sys_clk),
    .rst(rst),
    .ctrl(ctrl_reg),
    .subTick(subTick),
    .inhibit(countInhibit),
    .timerTick(timerTick)
  );

  // Counter step and overflow
  wire countStep = timerTick & ctrl_reg.countEnable;
  wire overflow = countStep & (count_reg == ebt_pkg::COUNT_MAX);
  wire loadNow = wrCount & ~ctrl_reg.countEnable;

  always_comb begin
    count_next = count_reg;
    if (loadNow) begin
      count_next = regWrData;
    end else if (overflow) begin
      count_next = preload_reg;
    end else if (countStep) begin
      count_next = count_reg + ebt_pkg::COUNT_STEP;
    end
  end

  // Control and preload registers
  wire [7:0] ctrlWord = {2'b00, ctrl_reg.srcSel, ctrl_reg.countEnable, 1'b0,
                         ctrl_reg.prescaleSel};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= ebt_pkg::ebt_ctrl_t'(ebt_pkg::CTRL_RESET[4:0]);
    end else if (wrCtrl) begin
      ctrl_reg.srcSel <= regWrData[ebt_pkg::CTRL_SRC_BIT];
      ctrl_reg.countEnable <= regWrData[ebt_pkg::CTRL_EN_BIT];
      ctrl_reg.prescaleSel <= regWrData[ebt_pkg::CTRL_PS_LSB +: ebt_pkg::PS_W];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      preload_reg <= ebt_pkg::PRELOAD_RESET;
      count_reg <= ebt_pkg::COUNT_RESET;
    end else begin
      if (wrCount) begin
        preload_reg <= regWrData;
      end
      count_reg <= count_next;
    end
  end

  // Interrupt events; an overflow flag already set suppresses the wake-up
  wire wakeEvent = overflow & powerDown & ~intStatus_reg[ebt_pkg::INT_OVF_BIT];
  wire [ebt_pkg::NUM_EVENTS-1:0] eventHit = {wakeEvent, overflow};

  genvar gi;
  generate
    for (gi = 0; gi < ebt_pkg::NUM_EVENTS; gi = gi + 1) begin : gStatus
      // Hardware set and software set both win over a same-cycle clear
      wire setBit = eventHit[gi] | (wrSet & regWrData[gi]);
      wire clrBit = wrStatus & regWrData[gi];
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          intStatus_reg[gi] <= ebt_pkg::INT_STATUS_RESET[gi];
        end else if (setBit) begin
          intStatus_reg[gi] <= 1'b1;
        end else if (clrBit) begin
          intStatus_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      intMask_reg <= ebt_pkg::INT_MASK_RESET;
      wakeup_reg <= 1'b0;
    end else begin
      if (wrMask) begin
        intMask_reg <= regWrData[ebt_pkg::NUM_EVENTS-1:0];
      end
      wakeup_reg <= wakeEvent;
    end
  end

  // Mask gating means a cleared enable keeps the flag but not the line
  assign irq = |(intStatus_reg & intMask_reg);
  assign wakeup = wakeup_reg;

  // Read path, data stands in the cycle after the strobe; unmapped reads zero
  always_comb begin
    rdData_next = 8'h00;
    if (regRdEn) begin
      case (1'b1)
        selCtrl: rdData_next = ctrlWord;
        selCount: rdData_next = count_reg;
        selStatus: rdData_next = {6'h00, intStatus_reg};
        selMask: rdData_next = {6'h00, intMask_reg};
        default: rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 8'h00;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  assign regRdData = rdData_reg;
endmodule : ebt_timer

/* File: rtl/ebt_pkg.sv */
// Shared constants and types for the eight-bit timer with prescaler
package ebt_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PS_W = 3;
  localparam int unsigned DIV_W = 7;
  localparam int unsigned NUM_EVENTS = 2;

  // Register offsets
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_COUNT = 4'h1;
  localparam logic [3:0] OFF_INT_STATUS = 4'h2;
  localparam logic [3:0] OFF_INT_MASK = 4'h3;
  localparam logic [3:0] OFF_INT_SET = 4'h4;

  // Control register field positions
  localparam int unsigned CTRL_SRC_BIT = 5;
  localparam int unsigned CTRL_EN_BIT = 4;
  localparam int unsigned CTRL_PS_LSB = 0;

  // Interrupt status and mask bit positions
  localparam int unsigned INT_OVF_BIT = 0;
  localparam int unsigned INT_WAKE_BIT = 1;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] PRELOAD_RESET = 8'h00;
  localparam logic [1:0] INT_STATUS_RESET = 2'h0;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [7:0] COUNT_STEP = 8'h01;

  typedef struct packed {
    logic srcSel;
    logic countEnable;
    logic [2:0] prescaleSel;
  } ebt_ctrl_t;
endpackage : ebt_pkg

/* File: rtl/ebt_edge_sync.sv */
// Two-stage synchroniser with rising-edge pulse for the sub-oscillator clock
`timescale 1ns/100ps
module ebt_edge_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic risePulse
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic risePulse_reg;
  wire riseSeen = stage2_reg & ~stage3_reg;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
      risePulse_reg <= 1'b0;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      risePulse_reg <= riseSeen;
    end
  end

  assign risePulse = risePulse_reg;
endmodule : ebt_edge_sync

/* File: rtl/ebt_prescaler.sv */
// Clock source select and binary prescaler producing the timer count enable
`timescale 1ns/100ps
module ebt_prescaler (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ebt_pkg::ebt_ctrl_t ctrl,
  input wire logic subTick,
  input wire logic inhibit,
  output logic timerTick
);
  logic [ebt_pkg::DIV_W-1:0] divCnt_reg;
  logic [ebt_pkg::DIV_W-1:0] divCnt_next;
  logic [7:0] ratioOne;
  logic [ebt_pkg::DIV_W-1:0] divMask;
  logic srcTick;
  logic gatedTick;

  // System clock gives a tick every cycle, sub-oscillator once per its period
  assign srcTick = ctrl.srcSel ? subTick : 1'b1;
  // Inhibit stops the source, so the divider phase is kept during an access
  assign gatedTick = srcTick & ctrl.countEnable & ~inhibit;
  assign ratioOne = 8'h01 << ctrl.prescaleSel;
  assign divMask = 7'(ratioOne - 8'h01);
  // The divided clock falls when all selected low divider bits wrap
  assign timerTick = gatedTick & ((divCnt_reg & divMask) == divMask);
  assign divCnt_next = divCnt_reg + 7'h01;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt_reg <= '0;
    end else if (!ctrl.countEnable) begin
      divCnt_reg <= '0;
    end else if (gatedTick) begin
      divCnt_reg <= divCnt_next;
    end
  end
endmodule : ebt_prescaler

/* File: bench/ebt_timer_properties.sv */
// Port-level assertions for the eight-bit timer
`timescale 1ns/100ps
module ebt_timer_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic subOscClk,
  input wire logic powerDown,
  input wire logic [ebt_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ebt_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [ebt_pkg::DATA_W-1:0] regRdData,
  input wire logic irq,
  input wire logic wakeup
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire rdCtrl = regRdEn && regAddr == ebt_pkg::OFF_CTRL;
  wire rdStat = regRdEn && regAddr == ebt_pkg::OFF_INT_STATUS;
  wire maskOff = regWrEn && regAddr == ebt_pkg::OFF_INT_MASK && regWrData[1:0] == 2'h0;
  wire rdHole = regRdEn && regAddr > ebt_pkg::OFF_INT_SET;
  read_slot_a: assert property (!$past(regRdEn) |-> regRdData == 8'h00)
    else $error("read data outside read slot");
  ctrl_bits_a: assert property (rdCtrl |=> (regRdData & 8'hc8) == 8'h00)
    else $error("control spare bits not zero");
  map_hole_a: assert property (rdHole |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  set_port_a: assert property (regRdEn && regAddr == ebt_pkg::OFF_INT_SET |=> regRdData == 8'h00)
    else $error("set port read not zero");
  status_bits_a: assert property (rdStat |=> regRdData[7:2] == 6'h00)
    else $error("status spare bits set");
  mask_off_a: assert property (maskOff |=> !irq)
    else $error("interrupt despite cleared enable");
  wake_pulse_a: assert property (wakeup |=> !wakeup)
    else $error("wake pulse too long");
  wake_pd_a: assert property (wakeup |-> $past(powerDown) || $past(powerDown, 2))
    else $error("wake outside power-down");
endmodule : ebt_timer_properties

bind ebt_timer ebt_timer_properties chk_u (.sys_clk(sys_clk), .rst(rst), .subOscClk(subOscClk),
  .powerDown(powerDown), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
  .regRdEn(regRdEn), .regRdData(regRdData), .irq(irq), .wakeup(wakeup));

/* File: bench/tb.sv */
// Self-checking bench for the eight-bit timer
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic subOscClk = 1'b0;
  logic powerDown = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regRdData;
  logic irq;
  logic wakeup;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int nWake = 0;
  logic [31:0] rngState = 32'h00011345;
  always #2.5 sys_clk = ~sys_clk;
  ebt_timer dut_u (.sys_clk(sys_clk), .rst(rst), .subOscClk(subOscClk), .powerDown(powerDown),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .irq(irq), .wakeup(wakeup));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results;
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 check(regRdData, exp);
  endtask : rd
  // Wake pulses are counted here so a late second pulse is never missed
  always @(posedge sys_clk) begin
    cyc++;
    if (wakeup === 1'b1) nWake++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    logic [7:0] v;
    int r;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd((a == 5) ? 4'hf : a[3:0], 8'h00);
    rngState = xorshift(rngState);
    v = rngState[7:0] & 8'hef;
    wr(4'h0, v);
    rd(4'h0, v & 8'h27);
    wr(4'h0, 8'h00);
    rngState = xorshift(rngState);
    v = rngState[7:0];
    wr(4'h1, v);
    rd(4'h1, v);
    // From a prescale ratio of 4 up the run length sits mid-step, so a one-cycle start skew cannot change the count
    for (int p = 0; p < 8; p++) begin
      r = 1 << p;
      wr(4'h1, 8'h00);
      wr(4'h0, 8'h10 | p[7:0]);
      repeat ((r == 1) ? 2 : 4 * r + r / 2 - 2) @(posedge sys_clk);
      wr(4'h0, 8'h00);
      rd(4'h1, 8'h04);
    end
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h30);
    for (int i = 0; i < 10; i++) begin
      rngState = xorshift(rngState);
      repeat (3 + rngState[1:0]) @(posedge sys_clk);
      subOscClk <= ~subOscClk;
    end
    repeat (12) @(posedge sys_clk);
    wr(4'h0, 8'h00);
    rd(4'h1, 8'h05);
    wr(4'h1, 8'hff);
    wr(4'h3, 8'h01);
    wr(4'h0, 8'h17);
    wr(4'h1, 8'h40);
    rd(4'h1, 8'hff);
    for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge sys_clk);
    check({7'h00, irq}, 8'h01);
    rd(4'h1, 8'h40);
    rd(4'h2, 8'h01);
    wr(4'h3, 8'h00);
    #1 check({7'h00, irq}, 8'h00);
    wr(4'h2, 8'h01);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hff);
    powerDown <= 1'b1;
    wr(4'h0, 8'h10);
    repeat (20) @(posedge sys_clk);
    check(nWake[7:0], 8'h01);
    rd(4'h2, 8'h03);
    wr(4'h3, 8'h02);
    #1 check({7'h00, irq}, 8'h01);
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h02);
    repeat (20) @(posedge sys_clk);
    check(nWake[7:0], 8'h01);
    rd(4'h2, 8'h01);
    // Flag preset through the set port must block the wake just as well
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h01);
    wr(4'h4, 8'h01);
    rd(4'h2, 8'h01);
    wr(4'h0, 8'h10);
    repeat (20) @(posedge sys_clk);
    check(nWake[7:0], 8'h01);
    powerDown <= 1'b0;
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h03);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h10);
    // The count read swallows one step, so the overflow lands one cycle late
    rd(4'h1, 8'h01);
    repeat (253) @(posedge sys_clk);
    rd(4'h2, 8'h00);
    rd(4'h2, 8'h01);
    wr(4'h0, 8'h00);
    results();
  end
endmodule : tb
